// File: actuator_model.sv
// Purpose: behavioural actuator with travel limits and feedback pot
// Assumes: one position code per clock while a motor output is on
// Notes: load is the current code the bench wants drawn
`timescale 1ns/100ps
module actuator_model
   import motor_prot_pkg::*;
#(
   parameter int SPAN = 40
)
(
   // clock
   input wire logic clk,
   // drive from the block
   input wire logic motor1_on,
   input wire logic motor2_on,
   input wire logic [CUR_W-1:0] load,
   // actuator side
   output logic limit1_closed,
   output logic limit2_closed,
   output logic [POS_W-1:0] position,
   output logic [CUR_W-1:0] motor_cur
);
   logic [POS_W-1:0] pos_q = 12'h800;
   // travel: motor1 moves up, motor2 down; no mechanical end stop
   always_ff @(posedge clk) begin
      if (motor1_on)
         pos_q <= pos_q + 12'h001;
      else if (motor2_on)
         pos_q <= pos_q - 12'h001;
   end
   // switches open past each end of travel
   assign limit1_closed = pos_q < 12'h800 + POS_W'(SPAN);
   assign limit2_closed = pos_q > 12'h800 - POS_W'(SPAN);
   assign position = pos_q;
   // an idle motor draws nothing
   assign motor_cur = (motor1_on || motor2_on) ? load : 8'h00;
endmodule

// File: actuator_motor_protection.sv
// Purpose: limit, current, stall, brake, duty cycle and command supervision of a DC actuator
// Assumes: converter codes arrive synchronous to clk; switch/override pins are asynchronous
// Notes: motor requests come from the positioning loop on the same clock
//
// What this block does
// - motor 1 drive blocked while limit switch 1 is open.
// - motor 2 drive blocked while limit switch 2 is open, independently.
// - after end positions are set, learn which switch belongs to open end.
// - flash the lamp of the end whose limit switch is reached.
// - drop fault relay output when either limit switch is reached.
// - current above trip setting stops that motor and flags a trip.
// - no motion with current above 0.62 A flags stall.
// - no motion with current below 0.62 A flags no-motion.
// - brake applied whenever motor is idle, except in override.
// - override mode releases the brake.
// - continuous run until hot, duty cycle until cooled.
// - duty cycle period about two seconds, on part set by heat.
// - flag loss of command below range-dependent low thresholds.
// - flag command out of range above range-dependent high thresholds.
// - current measured in 85 mA steps for trip and stall compares.
// - no-motion declared only after ten seconds without movement.
// - single-direction faults clear on movement over 1.5 degrees.
// - same fault in both directions stops both; command cannot clear.
`timescale 1ns/100ps
module actuator_motor_protection
(
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // motor requests from positioning loop
   input wire logic req_m1,
   input wire logic req_m2,
   input wire logic manual_op,
   // pins, asynchronous
   input wire logic limit1_closed,
   input wire logic limit2_closed,
   input wire logic override_mode,
   // converter codes
   input wire logic [motor_prot_pkg::CUR_W-1:0] motor_cur,
   input wire logic [motor_prot_pkg::CUR_W-1:0] trip_set,
   input wire logic [motor_prot_pkg::POS_W-1:0] position,
   input wire logic [motor_prot_pkg::CMD_W-1:0] cmd_level,
   input wire motor_prot_pkg::cmd_range_e cmd_range,
   // end position setup
   input wire logic ends_set,
   input wire logic m1_opens,
   // drive outputs
   output logic motor1_on,
   output logic motor2_on,
   output logic brake_on,
   // indication
   output motor_prot_pkg::lamps_s lamps,
   output logic fault_relay,
   output motor_prot_pkg::dir_fault_s fault_m1,
   output motor_prot_pkg::dir_fault_s fault_m2,
   output logic double_fault,
   output logic duty_mode,
   output logic cmd_loss,
   output logic cmd_oor
);
   import motor_prot_pkg::*;

   logic [1:0] lim1_s, lim2_s, ovr_s;
   logic lim1_ok, lim2_ok, ovr;
   logic m1_is_open_q;
   logic [POS_W-1:0] ref_pos_q;
   logic moved;
   dir_fault_s f1, f2;
   logic [CUR_W-1:0] trip_code;
   logic dbl, dbl_q;
   logic [HEAT_W-1:0] heat_q;
   logic [TMR_W-1:0] duty_cnt_q;
   logic [TMR_W-1:0] on_len;
   logic duty_q, duty_gate;
   logic [BLINK_BIT:0] blink_q;
   logic ok1, ok2, motor1_d, motor2_d;

   // two-stage synchronisers for the asynchronous pins
   always_ff @(posedge clk) begin
      if (rst) begin
         lim1_s <= '0;
         lim2_s <= '0;
         ovr_s <= '0;
      end else if (ce) begin
         lim1_s <= {lim1_s[0], limit1_closed};
         lim2_s <= {lim2_s[0], limit2_closed};
         ovr_s <= {ovr_s[0], override_mode};
      end
   end
   assign lim1_ok = lim1_s[1];
   assign lim2_ok = lim2_s[1];
   assign ovr = ovr_s[1];

   // trip setting clamped to the 0..15 A span
   assign trip_code = (trip_set > TRIP_MAX_CODE) ? TRIP_MAX_CODE : trip_set;

   // movement beyond 1.5 degrees from the reference point
   always_ff @(posedge clk) begin
      if (rst) begin
         ref_pos_q <= '0;
      end else if (ce && moved) begin
         ref_pos_q <= position;
      end
   end
   assign moved = (position > ref_pos_q) ? (position - ref_pos_q > MOVE_CODES)
                                         : (ref_pos_q - position > MOVE_CODES);

   // per-direction fault detectors
   dir_supervisor u_dir1 (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .driving(motor1_on),
      .cur(motor_cur),
      .trip_code(trip_code),
      .moved(moved),
      .fault(f1)
   );
   dir_supervisor u_dir2 (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .driving(motor2_on),
      .cur(motor_cur),
      .trip_code(trip_code),
      .moved(moved),
      .fault(f2)
   );

   // double fault: same type in both directions
   assign dbl = |(f1 & f2);

   // learned end association, latched when end positions are configured
   always_ff @(posedge clk) begin
      if (rst) begin
         m1_is_open_q <= 1'b1;
      end else if (ce && ends_set) begin
         m1_is_open_q <= m1_opens;
      end
   end

   // heat estimate: rises while driven, decays while idle
   always_ff @(posedge clk) begin
      if (rst) begin
         heat_q <= '0;
      end else if (ce) begin
         if (motor1_on || motor2_on) begin
            if (heat_q != '1) begin
               heat_q <= heat_q + 1'b1;
            end
         end else if (heat_q != '0) begin
            heat_q <= heat_q - 1'b1;
         end
      end
   end

   // hysteresis between continuous and duty-cycled running
   always_ff @(posedge clk) begin
      if (rst) begin
         duty_q <= 1'b0;
      end else if (ce) begin
         if (heat_q >= HEAT_HOT) begin
            duty_q <= 1'b1;
         end else if (heat_q <= HEAT_COOL) begin
            duty_q <= 1'b0;
         end
      end
   end

   // two-second period; on part shrinks as heat grows
   always_ff @(posedge clk) begin
      if (rst) begin
         duty_cnt_q <= '0;
      end else if (ce) begin
         if (!duty_q || duty_cnt_q == TMR_W'(DUTY_CYC - 1)) begin
            duty_cnt_q <= '0;
         end else begin
            duty_cnt_q <= duty_cnt_q + 1'b1;
         end
      end
   end
   // on length = period * (~heat)/65536, using all 16 heat bits
   assign on_len = TMR_W'((64'(DUTY_CYC) * 64'(HEAT_W'(~heat_q))) >> HEAT_W);
   assign duty_gate = !duty_q || (duty_cnt_q < on_len);

   // permission and next drive; trip drops the active output at once
   assign ok1 = lim1_ok && !dbl_q && (manual_op || !(|f1)) && duty_gate;
   assign ok2 = lim2_ok && !dbl_q && (manual_op || !(|f2)) && duty_gate;
   assign motor1_d = req_m1 && !req_m2 && ok1 && !(motor1_on && motor_cur > trip_code);
   assign motor2_d = req_m2 && !req_m1 && ok2 && !(motor2_on && motor_cur > trip_code);

   // double fault latch: only movement from manual action clears it
   always_ff @(posedge clk) begin
      if (rst) begin
         dbl_q <= 1'b0;
      end else if (ce) begin
         if (dbl) begin
            dbl_q <= 1'b1;
         end else if (moved) begin
            dbl_q <= 1'b0;
         end
      end
   end

   // motor drive; trip drops the active output at once
   always_ff @(posedge clk) begin
      if (rst) begin
         motor1_on <= 1'b0;
         motor2_on <= 1'b0;
      end else if (ce) begin
         motor1_on <= motor1_d;
         motor2_on <= motor2_d;
      end
   end

   // brake held whenever idle, released in override
   always_ff @(posedge clk) begin
      if (rst) begin
         brake_on <= 1'b1;
      end else if (ce) begin
         brake_on <= !ovr && !motor1_d && !motor2_d;
      end
   end

   // blink divider for lamps, about 2.4 Hz
   always_ff @(posedge clk) begin
      if (rst) begin
         blink_q <= '0;
      end else if (ce) begin
         blink_q <= blink_q + 1'b1;
      end
   end

   // lamps and fault relay; relay high means healthy
   always_ff @(posedge clk) begin
      if (rst) begin
         lamps <= '0;
         fault_relay <= 1'b0;
      end else if (ce) begin
         lamps.open_lamp <= blink_q[BLINK_BIT] &&
            (m1_is_open_q ? !lim1_ok : !lim2_ok);
         lamps.close_lamp <= blink_q[BLINK_BIT] &&
            (m1_is_open_q ? !lim2_ok : !lim1_ok);
         fault_relay <= lim1_ok && lim2_ok && !(|f1) && !(|f2)
            && !cmd_loss && !cmd_oor;
      end
   end

   // command supervision per selected range
   always_ff @(posedge clk) begin
      if (rst) begin
         cmd_loss <= 1'b0;
         cmd_oor <= 1'b0;
      end else if (ce) begin
         case (cmd_range)
            RNG_0_5V: begin
               cmd_loss <= 1'b0;
               cmd_oor <= cmd_level > OOR_5V;
            end
            RNG_1_5V: begin
               cmd_loss <= cmd_level < LOSS_1_5V;
               cmd_oor <= cmd_level > OOR_5V;
            end
            RNG_0_10V: begin
               cmd_loss <= 1'b0;
               cmd_oor <= cmd_level > OOR_10V;
            end
            RNG_2_10V: begin
               cmd_loss <= cmd_level < LOSS_2_10V;
               cmd_oor <= cmd_level > OOR_10V;
            end
            RNG_4_20MA: begin
               cmd_loss <= cmd_level < LOSS_MA;
               cmd_oor <= cmd_level > OOR_MA;
            end
            default: begin
               cmd_loss <= 1'b0;
               cmd_oor <= 1'b0;
            end
         endcase
      end
   end

   // registered status copies
   always_ff @(posedge clk) begin
      if (rst) begin
         fault_m1 <= '0;
         fault_m2 <= '0;
         double_fault <= 1'b0;
         duty_mode <= 1'b0;
      end else if (ce) begin
         fault_m1 <= f1;
         fault_m2 <= f2;
         double_fault <= dbl_q;
         duty_mode <= duty_q;
      end
   end
endmodule

// File: dir_supervisor.sv
// Purpose: fault detection for one motor direction
// Assumes: cur and trip are 85 mA codes, moved is a one-cycle pulse
// Notes: instantiated once per direction
`timescale 1ns/100ps
module dir_supervisor
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // observation
   input wire logic driving,
   input wire logic [motor_prot_pkg::CUR_W-1:0] cur,
   input wire logic [motor_prot_pkg::CUR_W-1:0] trip_code,
   input wire logic moved,
   // result
   output motor_prot_pkg::dir_fault_s fault
);
   import motor_prot_pkg::*;
   logic [TMR_W-1:0] still_q;
   dir_fault_s fault_q;
   assign fault = fault_q;

   // time without movement while driven
   always_ff @(posedge clk) begin
      if (rst) begin
         still_q <= '0;
      end else if (ce) begin
         if (!driving || moved) begin
            still_q <= '0;
         end else if (still_q != TMR_W'(NOMO_CYC)) begin
            still_q <= still_q + 1'b1;
         end
      end
   end

   // fault flags; detection wins over clearing by movement
   always_ff @(posedge clk) begin
      if (rst) begin
         fault_q <= '0;
      end else if (ce) begin
         if (moved) begin
            fault_q <= '0;
         end
         if (driving && cur > trip_code) begin
            fault_q.trip <= 1'b1;
         end
         if (driving && still_q == TMR_W'(NOMO_CYC) && !moved) begin
            if (cur > STALL_CODE) begin
               fault_q.stall <= 1'b1;
            end else begin
               fault_q.nomo <= 1'b1;
            end
         end
      end
   end
endmodule

// File: motor_prot_assertions.sv
// Purpose: concurrent checks on the protection block ports
// Assumes: ce held high by the bench
// Notes: repetition counts cover the two-flop pin synchronisers
`timescale 1ns/100ps
module motor_prot_assertions
   import motor_prot_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // inputs watched
   input wire logic req_m1,
   input wire logic req_m2,
   input wire logic limit1_closed,
   input wire logic limit2_closed,
   input wire logic override_mode,
   input wire logic [CUR_W-1:0] motor_cur,
   input wire logic [CUR_W-1:0] trip_set,
   input wire logic [CMD_W-1:0] cmd_level,
   input wire cmd_range_e cmd_range,
   // outputs watched
   input wire logic motor1_on,
   input wire logic motor2_on,
   input wire logic brake_on,
   input wire logic fault_relay,
   input wire dir_fault_s fault_m1,
   input wire logic cmd_loss,
   input wire logic cmd_oor
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // pins pass two sync flops, so allow a margin of cycles
   a_one_dir_only: assert property (!(motor1_on && motor2_on))
      else $error("both motor outputs on");
   a_limit1_block: assert property (!limit1_closed [*4] |=> !motor1_on)
      else $error("motor1 on with limit1 open");
   a_limit2_block: assert property (!limit2_closed [*4] |=> !motor2_on)
      else $error("motor2 on with limit2 open");
   a_limit_relay: assert property (!limit1_closed [*4] |=> !fault_relay)
      else $error("relay healthy at limit");
   a_brake_idle: assert property (
      (!override_mode && !req_m1 && !req_m2) [*5] |=> brake_on)
      else $error("brake off while idle");
   a_brake_override: assert property (override_mode [*5] |=> !brake_on)
      else $error("brake on in override");
   a_trip_stop: assert property (motor1_on && motor_cur > trip_set |=> !motor1_on)
      else $error("motor1 kept on above trip");
   a_trip_flag: assert property (motor1_on && motor_cur > trip_set |=> ##2 fault_m1.trip)
      else $error("trip flag missing");
   a_cmd_loss: assert property (
      (cmd_range == RNG_4_20MA && cmd_level < LOSS_MA) [*2] |=> cmd_loss)
      else $error("loop loss not flagged");
   a_cmd_oor: assert property (
      (cmd_range == RNG_0_10V && cmd_level > OOR_10V) [*2] |=> cmd_oor)
      else $error("high command not flagged");
endmodule

// File: motor_prot_pkg.sv
// Purpose: shared constants and carriers for the actuator motor protection block
// Assumes: 20 MHz clk, current code in 85 mA steps, command/feedback as digital codes
// Notes: analog levels are expressed as input codes from an external converter
package motor_prot_pkg;
   localparam int unsigned CLK_HZ = 20_000_000;
   // current measurement: one code step is 85 mA
   localparam int unsigned CUR_STEP_MA = 85;
   localparam int unsigned CUR_W = 8;
   localparam int unsigned STALL_MA = 620;
   localparam logic [CUR_W-1:0] STALL_CODE = CUR_W'(STALL_MA / CUR_STEP_MA);
   // trip setting code spans 0..15 A
   localparam int unsigned TRIP_MAX_MA = 15000;
   localparam logic [CUR_W-1:0] TRIP_MAX_CODE = CUR_W'(TRIP_MAX_MA / CUR_STEP_MA);
   // times
   localparam int unsigned NOMO_S = 10;
   localparam int unsigned DUTY_MS = 2000;
   localparam int unsigned NOMO_CYC = NOMO_S * CLK_HZ;
   localparam int unsigned DUTY_CYC = (DUTY_MS / 1000) * CLK_HZ;
   localparam int unsigned TMR_W = 28;
   // lamp flash divider tap, about 2.4 Hz at 20 MHz
   localparam int unsigned BLINK_BIT = 22;
   // feedback: 1.5 degree as position codes (0.1875 deg per code assumed)
   localparam int unsigned POS_W = 12;
   localparam logic [POS_W-1:0] MOVE_CODES = 12'h008;
   // heat estimate
   localparam int unsigned HEAT_W = 16;
   localparam logic [HEAT_W-1:0] HEAT_HOT = 16'hc000;
   localparam logic [HEAT_W-1:0] HEAT_COOL = 16'h4000;
   // command codes in millivolts or microamps/10 (mA*100)
   localparam int unsigned CMD_W = 16;
   localparam logic [CMD_W-1:0] LOSS_1_5V = 16'h02ee;
   localparam logic [CMD_W-1:0] LOSS_2_10V = 16'h05dc;
   localparam logic [CMD_W-1:0] LOSS_MA = 16'h012c;
   localparam logic [CMD_W-1:0] OOR_5V = 16'h1482;
   localparam logic [CMD_W-1:0] OOR_10V = 16'h2904;
   localparam logic [CMD_W-1:0] OOR_MA = 16'h0834;
   // command range select
   typedef enum logic [2:0] {
      RNG_0_5V, RNG_1_5V, RNG_0_10V, RNG_2_10V, RNG_4_20MA
   } cmd_range_e;
   // per-direction fault flags
   typedef struct packed {
      logic trip;
      logic stall;
      logic nomo;
   } dir_fault_s;
   // lamps
   typedef struct packed {
      logic close_lamp;
      logic open_lamp;
   } lamps_s;
endpackage

// File: tb.sv
// Purpose: self-checking bench of the protection block
// Assumes: 10 s and 2 s timers too long to reach here
// Notes: stall, no-motion and duty cycling need shortened package timers
`timescale 1ns/100ps
module tb;
   import motor_prot_pkg::*;
   logic clk = 0, rst = 1, req_m1 = 0, req_m2 = 0, override_mode = 0;
   logic ends_set = 0, m1_opens = 1, limit1_closed, limit2_closed;
   logic motor1_on, motor2_on, brake_on, fault_relay, double_fault, cmd_loss, cmd_oor;
   logic [CUR_W-1:0] load = 8'h05, trip_set = 8'h40, motor_cur;
   logic [POS_W-1:0] position;
   logic [CMD_W-1:0] cmd_level = 16'd1200, lv;
   logic [31:0] rng = 32'd78;
   cmd_range_e cmd_range = RNG_4_20MA;
   dir_fault_s fault_m1, fault_m2;
   logic duty_mode;
   int n_fail = 0, checked = 0, i;
   // clock
   initial forever #25 clk = ~clk;
   actuator_motor_protection dut (.clk, .rst, .ce(1'b1), .req_m1, .req_m2,
      .manual_op(1'b0), .limit1_closed, .limit2_closed, .override_mode, .motor_cur,
      .trip_set, .position, .cmd_level, .cmd_range, .ends_set, .m1_opens, .motor1_on,
      .motor2_on, .brake_on, .lamps(), .fault_relay, .fault_m1, .fault_m2,
      .double_fault, .duty_mode, .cmd_loss, .cmd_oor);
   actuator_model model (.clk, .motor1_on, .motor2_on, .load, .limit1_closed,
      .limit2_closed, .position, .motor_cur);
   function automatic logic [31:0] xs(logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   // low and high command thresholds per range
   function automatic logic [15:0] lo_of(cmd_range_e r);
      case (r)
         RNG_1_5V: return LOSS_1_5V;
         RNG_2_10V: return LOSS_2_10V;
         RNG_4_20MA: return LOSS_MA;
         default: return 16'h0000;
      endcase
   endfunction
   function automatic logic [15:0] hi_of(cmd_range_e r);
      case (r)
         RNG_0_5V, RNG_1_5V: return OOR_5V;
         RNG_4_20MA: return OOR_MA;
         default: return OOR_10V;
      endcase
   endfunction
   task automatic step(int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
      checked++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", nm, exp, got);
         n_fail++;
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // hold the request until the selected output drops, bounded
   task automatic travel(bit up);
      for (i = 0; i < 300 && (up ? motor1_on : motor2_on) !== 1'b0; i++)
         step(1);
      if (i == 300) begin
         $display("unexpected travel stop expected %h seen %h", 1'b0, 1'b1);
         n_fail++;
         end_of_test();
      end
   endtask
   initial begin
      step(5);
      chk("reset m1", 0, motor1_on);
      chk("reset brake", 1, brake_on);
      rst = 0;
      ends_set = 1;
      step(4);
      ends_set = 0;
      chk("idle brake", 1, brake_on);
      req_m1 = 1;
      step(2);
      chk("run brake", 0, brake_on);
      travel(1);
      chk("limit1", 0, limit1_closed);
      chk("relay", 0, fault_relay);
      {req_m1, req_m2} = 2'b01;
      step(12);
      {req_m1, req_m2} = 2'b10;
      step(2);
      chk("m1 again", 1, motor1_on);
      chk("relay ok", 1, fault_relay);
      {req_m1, req_m2} = 2'b01;
      step(2);
      travel(0);
      chk("limit2", 0, limit2_closed);
      chk("duty", 0, duty_mode);
      {req_m1, req_m2} = 2'b10;
      step(2);
      chk("m1 free", 1, motor1_on);
      step(40);
      req_m2 = 1;
      step(2);
      chk("both m1", 0, motor1_on | motor2_on);
      {req_m1, req_m2} = 2'b00;
      override_mode = 1;
      step(6);
      chk("override", 0, brake_on);
      override_mode = 0;
      load = 8'h40;
      req_m1 = 1;
      step(4);
      chk("at trip", 1, motor1_on);
      load = 8'h41;
      step(2);
      chk("trip off", 0, motor1_on);
      step(1);
      chk("trip flag", 1, fault_m1.trip);
      load = 8'h05;
      {req_m1, req_m2} = 2'b01;
      step(16);
      chk("cleared", 0, fault_m1.trip);
      load = 8'hff;
      {req_m1, req_m2} = 2'b10;
      step(4);
      {req_m1, req_m2} = 2'b01;
      step(4);
      chk("double", 1, double_fault);
      chk("double m2", 1, fault_m2.trip);
      {req_m1, req_m2} = 2'b10;
      step(3);
      chk("double m1", 0, motor1_on);
      rst = 1;
      step(5);
      chk("rereset", 0, motor1_on | double_fault);
      {rst, req_m1} = 2'b00;
      // command ranges: threshold corners first, then random levels
      for (int k = 0; k < 60; k++) begin
         rng = xs(rng);
         cmd_range = cmd_range_e'(3'(k < 20 ? k % 5 : rng % 5));
         case (k < 20 ? k / 5 : 4)
            0: lv = lo_of(cmd_range) - 16'h0001;
            1: lv = lo_of(cmd_range);
            2: lv = hi_of(cmd_range);
            3: lv = hi_of(cmd_range) + 16'h0001;
            default: lv = 16'(rng[31:16] % 12000);
         endcase
         cmd_level = lv;
         step(3);
         chk("cmd_loss", 16'(lv < lo_of(cmd_range)), cmd_loss);
         chk("cmd_oor", 16'(lv > hi_of(cmd_range)), cmd_oor);
      end
      end_of_test();
   end
endmodule
bind actuator_motor_protection motor_prot_assertions chk_i (.clk, .rst, .req_m1, .req_m2,
   .limit1_closed, .limit2_closed, .override_mode, .motor_cur, .trip_set, .cmd_level,
   .cmd_range, .motor1_on, .motor2_on, .brake_on, .fault_relay, .fault_m1, .cmd_loss,
   .cmd_oor);
